// *** src/lin_sync_logic.sv ***
// lin slave break and sync byte timing with its register file
// assumes linRxd comes from the transceiver pin, unsynchronised
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lin_sync_logic
    import lin_sync_pkg::*;
#(
    parameter int BRK_DIV = 100
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [31:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // lin side
    input wire logic linRxd,
    output logic uartRxd,
    output logic transceiverTestMode,
    // interrupt request
    output logic linIrq
);
    typedef enum {SY_IDLE, SY_BREAK, SY_ARMED, SY_TIMING, SY_DONE} syncState_t;

    logic [7:0] statusQ;
    logic [7:0] statusD;
    logic [15:0] ctrl0Q;
    logic [7:0] edgeSelQ;
    logic [15:0] syncCmpQ;
    logic [11:0] brkCmpQ;
    logic [11:0] brkCntQ;
    logic [11:0] brkCntD;
    logic [15:0] syncCntQ;
    logic [3:0] fallCntQ;
    logic [3:0] riseCntQ;
    logic [3:0] fallCntD;
    logic [3:0] riseCntD;
    logic [31:0] rdDataQ;
    logic rstDoneQ;
    logic rxMetaQ;
    logic rxSyncQ;
    logic rxPrevQ;
    logic [7:0] syncDivQ;
    logic [15:0] brkDivQ;
    syncState_t stateQ;
    syncState_t stateD;

    // -- register decode
    wire logic selStatus = regAddr == ADDR_STATUS;
    wire logic selCtrl0 = regAddr == ADDR_CTRL0;
    wire logic selEdge = regAddr == ADDR_EDGESEL;
    wire logic selSyncCmp = regAddr == ADDR_SYNCCMP;
    wire logic selSyncVal = regAddr == ADDR_SYNCVAL;
    wire logic selBrkCmp = regAddr == ADDR_BRKCMP;
    wire logic selBrkVal = regAddr == ADDR_BRKVAL;
    wire logic rdStatus = regRd && selStatus;
    wire logic rstCmd = regWr && selCtrl0 && regWrData[C0_RESET_CMD];

    // -- tick dividers, one-cycle enables
    wire logic syncTick = syncDivQ == 8'(SYNC_DIV - 1);
    wire logic brkTick = brkDivQ == 16'(BRK_DIV - 1);

    // -- line edges, after the synchroniser
    wire logic rxFall = rxPrevQ && !rxSyncQ;
    wire logic rxRise = !rxPrevQ && rxSyncQ;

    // R6 break overflow
    wire logic brkOvf = brkTick && !rxSyncQ && brkCntQ == 12'hfff;
    // R10 break compare
    wire logic brkHit = brkTick && !rxSyncQ && brkCntQ != 12'hfff &&
        brkCntQ + 12'h001 == brkCmpQ;
    wire logic [3:0] startSel = edgeSelQ[3:0];
    wire logic [3:0] stopSel = edgeSelQ[7:4];
    // R9 start condition
    wire logic startHit = stateQ == SY_ARMED && rxFall &&
        fallCntD == startSel;
    // R8 R13 R17 stop edge choice
    wire logic stopHit = stateQ == SY_TIMING && (ctrl0Q[C0_STOP_RISE] ?
        (rxRise && riseCntD == stopSel) : (rxFall && fallCntD == stopSel));
    // R7 sync compare
    wire logic cmpHit = stateQ == SY_TIMING && syncTick &&
        syncCntQ + 16'h0001 == syncCmpQ;

    wire logic [7:0] setVec = {2'b00, rstDoneQ, brkOvf, cmpHit, stopHit,
        startHit, brkHit};

    // R16 R18 enables for the shared request
    wire logic [7:0] irqMask = {2'b00, 1'b0,
        !ctrl0Q[C0_BRK_ERR_DIS], ctrl0Q[C0_CMP_IE], ctrl0Q[C0_STOP_IE],
        ctrl0Q[C0_START_IE], !ctrl0Q[C0_BRK_CMP_DIS]};

    wire logic [31:0] rdMux =
        selStatus ? {24'h000000, statusQ} :
        selCtrl0 ? {16'h0000, ctrl0Q} :
        selEdge ? {24'h000000, edgeSelQ} :
        selSyncCmp ? {16'h0000, syncCmpQ} :
        selSyncVal ? {16'h0000, syncCntQ} :
        selBrkCmp ? {20'h00000, brkCmpQ} :
        selBrkVal ? {20'h00000, brkCntQ} : 32'h00000000;

    // R11 clear on read, a new event wins over the clear
    assign statusD = ((statusQ & ~{8{rdStatus}}) | setVec) & 8'h3f;

    // R2 R18 one level request from the status flags
    assign linIrq = |(statusQ & irqMask);
    // R15 uart gated high until break and sync byte seen
    assign uartRxd = (ctrl0Q[C0_GATE_UART] && stateQ != SY_DONE) ?
        1'b1 : rxSyncQ;
    assign transceiverTestMode = ctrl0Q[C0_TEST_MODE];
    assign regRdData = rdDataQ;

    // the break count clears on any high level so only one low run counts
    assign brkCntD = rxSyncQ ? 12'h000 :
        (brkTick ? brkCntQ + 12'h001 : brkCntQ);
    assign fallCntD = (stateQ == SY_ARMED || stateQ == SY_TIMING) && rxFall ?
        fallCntQ + 4'h1 : fallCntQ;
    assign riseCntD = (stateQ == SY_ARMED || stateQ == SY_TIMING) && rxRise ?
        riseCntQ + 4'h1 : riseCntQ;

    always_comb
    begin
        stateD = stateQ;
        case (stateQ)
            SY_IDLE:
            begin
                if (brkHit)
                    stateD = SY_BREAK;
            end
            SY_BREAK:
            begin
                if (rxRise)
                    stateD = SY_ARMED;
            end
            SY_ARMED:
            begin
                if (startHit)
                    stateD = SY_TIMING;
            end
            SY_TIMING:
            begin
                if (stopHit)
                    stateD = SY_DONE;
            end
            SY_DONE:
            begin
                if (brkHit)
                    stateD = SY_BREAK;
            end
            default:
                stateD = SY_IDLE;
        endcase
        if (brkOvf)
            stateD = SY_IDLE;
    end

    // R3 two pin flops before the line is read
    always_ff @(posedge clk)
    begin
        rxMetaQ <= linRxd;
        rxSyncQ <= rxMetaQ;
        if (!rst_n)
            rxPrevQ <= 1'b1;
        else
            rxPrevQ <= rxSyncQ;
    end

    // R3 tick dividers
    always_ff @(posedge clk)
    begin
        if (!rst_n || syncTick)
            syncDivQ <= 8'h00;
        else
            syncDivQ <= syncDivQ + 8'h01;
        if (!rst_n || brkTick)
            brkDivQ <= 16'h0000;
        else
            brkDivQ <= brkDivQ + 16'h0001;
    end

    // R4 R12 registers reset to zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            statusQ <= STATUS_RESET;
            ctrl0Q <= CTRL0_RESET;
            edgeSelQ <= EDGESEL_RESET;
            syncCmpQ <= SYNCCMP_RESET;
            brkCmpQ <= BRKCMP_RESET;
            rdDataQ <= 32'h00000000;
            rstDoneQ <= 1'b0;
        end
        else
        begin
            statusQ <= statusD;
            rdDataQ <= regRd ? rdMux : 32'h00000000;
            // R5 reset complete one cycle after the command
            rstDoneQ <= rstCmd;
            // reset command bit is a strobe and reads back zero
            if (regWr && selCtrl0)
                ctrl0Q <= regWrData[15:0] & CTRL0_WMASK &
                    ~(16'h0001 << C0_RESET_CMD);
            if (regWr && selEdge)
                edgeSelQ <= regWrData[7:0];
            if (regWr && selSyncCmp)
                syncCmpQ <= regWrData[15:0];
            if (regWr && selBrkCmp)
                brkCmpQ <= regWrData[11:0];
        end
    end

    // R1 R6 R14 timers and sync state
    always_ff @(posedge clk)
    begin
        if (!rst_n || rstCmd)
        begin
            stateQ <= SY_IDLE;
            brkCntQ <= 12'h000;
            syncCntQ <= 16'h0000;
            fallCntQ <= 4'h0;
            riseCntQ <= 4'h0;
        end
        else
        begin
            stateQ <= stateD;
            brkCntQ <= brkCntD;
            if (stateQ == SY_BREAK)
            begin
                fallCntQ <= 4'h0;
                riseCntQ <= 4'h0;
            end
            else
            begin
                fallCntQ <= fallCntD;
                riseCntQ <= riseCntD;
            end
            if (startHit)
                syncCntQ <= 16'h0000;
            else if (stateQ == SY_TIMING && syncTick && !stopHit)
                syncCntQ <= syncCntQ + 16'h0001;
        end
    end

    // R4 status zero after reset
    a_status_after_reset: assert property (@(posedge clk) // R4
        $past(!rst_n) |-> statusQ == 8'h00)
        else $error("status not zero after reset");
    // R5 reset complete flag follows command
    a_reset_done_flag: assert property (@(posedge clk) // R5
        disable iff (!rst_n) rstCmd |-> ##2 statusQ[ST_RST_DONE])
        else $error("reset complete flag missing");
    // R6 overflow sets error flag
    a_break_err_flag: assert property (@(posedge clk) // R6
        disable iff (!rst_n) brkOvf |=> statusQ[ST_BRK_ERR])
        else $error("break error flag missing");
    // R7 compare sets flag
    a_sync_cmp_flag: assert property (@(posedge clk) // R7
        disable iff (!rst_n) cmpHit |=> statusQ[ST_SYNC_CMP])
        else $error("sync compare flag missing");
    // R8 stop sets flag and moves the sync state to done
    a_stop_flag_set: assert property (@(posedge clk) // R8
        disable iff (!rst_n)
        stopHit && !rstCmd |=> statusQ[ST_STOP] && stateQ == SY_DONE)
        else $error("stop flag or state wrong");
    // R9 start sets flag and zeroes timer
    a_start_flag_set: assert property (@(posedge clk) // R9
        disable iff (!rst_n)
        startHit && !rstCmd |=> statusQ[ST_START] && syncCntQ == 16'h0000)
        else $error("start flag or timer wrong");
    // R10 break compare sets flag
    a_break_cmp_flag: assert property (@(posedge clk) // R10
        disable iff (!rst_n) brkHit |=> statusQ[ST_BRK_CMP])
        else $error("break compare flag missing");
    // R11 read clears when no event races it
    a_read_clears: assert property (@(posedge clk) // R11
        disable iff (!rst_n) rdStatus && setVec == 8'h00 |=>
        statusQ == 8'h00 && regRdData == {24'h000000, $past(statusQ)})
        else $error("status read did not clear");
    // R15 uart held high while gated
    a_uart_gate_high: assert property (@(posedge clk) // R15
        disable iff (!rst_n) ctrl0Q[C0_GATE_UART] && stateQ != SY_DONE |->
        uartRxd)
        else $error("uart receive not gated");
    // R16 R18 request stays until status read
    a_irq_held: assert property (@(posedge clk) // R18
        disable iff (!rst_n) linIrq && !rdStatus && !regWr |=> linIrq)
        else $error("interrupt dropped without read");
    // R3 sync tick spacing
    a_sync_tick_gap: assert property (@(posedge clk) // R3
        disable iff (!rst_n) syncTick |=> !syncTick [*8])
        else $error("sync tick too frequent");
    // R12 reserved control bits read zero
    a_ctrl_reserved: assert property (@(posedge clk) // R12
        disable iff (!rst_n)
        (ctrl0Q & ~CTRL0_WMASK) == 16'h0000 && !ctrl0Q[C0_RESET_CMD])
        else $error("reserved control bit set");
    // R4 read data only in the cycle after a read
    a_read_data_idle: assert property (@(posedge clk) // R4
        disable iff (!rst_n) !$past(regRd) |-> regRdData == 32'h00000000)
        else $error("read data outside read cycle");
    // R12 written control value lands, masked
    a_ctrl_write_value: assert property (@(posedge clk) // R12
        disable iff (!rst_n) regWr && selCtrl0 |=>
        ctrl0Q == ($past(regWrData[15:0]) & CTRL0_WMASK & 16'hfffe))
        else $error("control write not taken");
    // R5 reset command returns the sync logic to idle
    a_reset_cmd_idle: assert property (@(posedge clk) // R5
        disable iff (!rst_n)
        rstCmd |=> stateQ == SY_IDLE && syncCntQ == 16'h0000)
        else $error("reset command did not clear");
    // R6 overflow wraps the break timer and drops to idle
    a_overflow_idle: assert property (@(posedge clk) // R6
        disable iff (!rst_n)
        brkOvf && !rstCmd |=> stateQ == SY_IDLE && brkCntQ == 12'h000)
        else $error("overflow did not return to idle");
    // R6 a high line clears the break timer
    a_break_count_clear: assert property (@(posedge clk) // R6
        disable iff (!rst_n) rxSyncQ |=> brkCntQ == 12'h000)
        else $error("break timer not cleared");
    // R6 break timer steps on each low tick
    a_break_count_step: assert property (@(posedge clk) // R6
        disable iff (!rst_n) brkTick && !rxSyncQ && !rstCmd |=>
        brkCntQ == $past(brkCntQ) + 12'h001)
        else $error("break timer did not step");
    // R14 sync timer only moves while timing
    a_sync_timer_hold: assert property (@(posedge clk) // R14
        disable iff (!rst_n)
        stateQ != SY_TIMING && !startHit && !rstCmd |=> $stable(syncCntQ))
        else $error("sync timer moved outside timing");
    // R14 sync timer steps on each 5 MHz tick
    a_sync_timer_step: assert property (@(posedge clk) // R14
        disable iff (!rst_n) stateQ == SY_TIMING && syncTick && !stopHit &&
        !rstCmd |=> syncCntQ == $past(syncCntQ) + 16'h0001)
        else $error("sync timer did not step");
    // R11 reserved status bits stay zero
    a_status_reserved: assert property (@(posedge clk) // R11
        disable iff (!rst_n) statusQ[7:6] == 2'b00)
        else $error("reserved status bit set");
    // R16 all sources masked keeps the request low
    a_irq_masked: assert property (@(posedge clk) // R16
        disable iff (!rst_n) ctrl0Q[C0_BRK_ERR_DIS] &&
        ctrl0Q[C0_BRK_CMP_DIS] && ctrl0Q[C0_STOP_IE:C0_CMP_IE] == 3'b000 |->
        !linIrq)
        else $error("masked interrupt raised");
    // R18 a read with no new event drops the request
    a_irq_read_drop: assert property (@(posedge clk) // R18
        disable iff (!rst_n) rdStatus && setVec == 8'h00 |=> !linIrq)
        else $error("interrupt held after read");
    // R15 uart follows the line once gating ends
    a_uart_follow: assert property (@(posedge clk) // R15
        disable iff (!rst_n) !ctrl0Q[C0_GATE_UART] || stateQ == SY_DONE |->
        uartRxd == rxSyncQ)
        else $error("uart receive not following line");
endmodule
`default_nettype wire

// *** src/lin_sync_pkg.sv ***
// constants for the lin slave hardware synchronisation block
// assumes one 100 MHz clock and a simple one-cycle register port
//
// What this block does
// R1 - slave only; timers sized for bus rates of 1 to 20 kBaud
// R2 - uart, interrupt line, lin timer and transceiver do protocol work
// R3 - break timer on low-power tick, sync timer on 5 MHz tick
// R4 - status register is 8 bits, read only, at fixed address, resets zero
// R5 - status bit 5 sets when a sync logic reset command completes
// R6 - status bit 4 and interrupt when the 12-bit break timer overflows
// R7 - status bit 3 sets when sync timer equals sync compare value
// R8 - status bit 2 sets when the stop edge condition is seen
// R9 - status bit 1 sets when the start edge condition is seen
// R10 - status bit 0 sets when break timer reaches break compare value
// R11 - reading status clears all flags; bits 7 and 6 read zero
// R12 - control register 0 is 16 bits, read/write, fixed address, resets zero
// R13 - edge select register picks sync timer start and stop edges
// R14 - sync bit timer is a 16-bit counter governed by control register 0
// R15 - control bit 8 holds uart receive high until break and sync seen
// R16 - control bit 11 masks break compare irq, bit 10 break error irq
// R17 - control bit 7 stops sync timer on falling (0) or rising (1) count
// R18 - enabled status events form one level irq held until status read
package lin_sync_pkg;
    localparam logic [31:0] ADDR_STATUS = 32'hffff0780;
    localparam logic [31:0] ADDR_CTRL0 = 32'hffff0784;
    localparam logic [31:0] ADDR_EDGESEL = 32'hffff0788;
    localparam logic [31:0] ADDR_SYNCCMP = 32'hffff078c;
    localparam logic [31:0] ADDR_SYNCVAL = 32'hffff0790;
    localparam logic [31:0] ADDR_BRKCMP = 32'hffff0794;
    localparam logic [31:0] ADDR_BRKVAL = 32'hffff0798;

    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [15:0] CTRL0_RESET = 16'h0000;
    localparam logic [7:0] EDGESEL_RESET = 8'h00;
    localparam logic [15:0] SYNCCMP_RESET = 16'h0000;
    localparam logic [11:0] BRKCMP_RESET = 12'h000;
    // writable control bits; reserved ones read zero
    localparam logic [15:0] CTRL0_WMASK = 16'h0f9f;

    localparam int ST_BRK_CMP = 0;
    localparam int ST_START = 1;
    localparam int ST_STOP = 2;
    localparam int ST_SYNC_CMP = 3;
    localparam int ST_BRK_ERR = 4;
    localparam int ST_RST_DONE = 5;

    localparam int C0_RESET_CMD = 0;
    localparam int C0_CMP_IE = 2;
    localparam int C0_START_IE = 3;
    localparam int C0_STOP_IE = 4;
    localparam int C0_STOP_RISE = 7;
    localparam int C0_GATE_UART = 8;
    localparam int C0_TEST_MODE = 9;
    localparam int C0_BRK_ERR_DIS = 10;
    localparam int C0_BRK_CMP_DIS = 11;

    localparam int CLK_HZ = 100_000_000;
    localparam int SYNC_TICK_HZ = 5_000_000;
    localparam int SYNC_DIV = CLK_HZ / SYNC_TICK_HZ;
    localparam int BAUD_MIN = 1_000;
    localparam int BAUD_MAX = 20_000;
endpackage

// *** testbench/lin_master_model.sv ***
// behavioural lin master that drives the receive line of the slave
// assumes the caller starts each task right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module lin_master_model
#(
    parameter int BIT_CLKS = 40
)
(
    // clock
    input wire logic clk,
    // lin line toward the slave
    output logic linRxd
);
    // the bus has a pull-up, so an idle line reads high
    initial linRxd = 1'b1;

    task automatic hold(input logic v, input int clks);
        linRxd <= v;
        repeat (clks) @(posedge clk);
    endtask

    // break of bits low, then a one-bit delimiter high
    task automatic sendBreak(input int bits);
        hold(1'b0, bits * BIT_CLKS);
        hold(1'b1, BIT_CLKS);
    endtask

    // bit time is shortened so that a frame stays a few hundred cycles
    task automatic sendByte(input logic [7:0] b);
        hold(1'b0, BIT_CLKS);
        for (int i = 0; i < 8; i++)
        begin
            hold(b[i], BIT_CLKS);
        end
        hold(1'b1, BIT_CLKS);
    endtask
endmodule
`default_nettype wire

// *** testbench/lin_sync_logic_tb.sv ***
// self-checking bench for the lin break and sync timing block
// assumes lin_master_model drives the line with a shortened bit time
`timescale 1ns/1ps
`default_nettype none
module lin_sync_logic_tb;
    import lin_sync_pkg::*;
    logic clk;
    logic rst_n;
    logic [31:0] regAddr;
    logic [31:0] regWrData;
    logic regWr;
    logic regRd;
    logic [31:0] regRdData;
    wire logic linRxd;
    logic uartRxd;
    logic testMode;
    logic linIrq;
    logic [31:0] rdVal;
    int n_errors;
    int tests_run;

    lin_sync_logic #(.BRK_DIV(4)) lin_sync_logic_i (
        .clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .linRxd(linRxd), .uartRxd(uartRxd),
        .transceiverTestMode(testMode), .linIrq(linIrq));

    lin_master_model #(.BIT_CLKS(40)) lin_master_model_i (
        .clk(clk), .linRxd(linRxd));

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic chkRange(input string name, input logic [31:0] v,
                            input logic [31:0] lo, input logic [31:0] hi);
        chk(name, {31'h0, (v >= lo) && (v <= hi)}, 32'h1);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [31:0] a);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        rdVal = regRdData;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic resetValues();
        rd(ADDR_STATUS);
        chk("status", rdVal, 32'h0000_0000);
        rd(ADDR_CTRL0);
        chk("ctrl0", rdVal, 32'h0000_0000);
        rd(32'hffff_07fc);
        chk("unmapped", rdVal, 32'h0000_0000);
        chk("testMode", {31'h0, testMode}, 32'h0);
    endtask

    task automatic ctrlAccess();
        wr(ADDR_CTRL0, 32'hffff_fffe);
        rd(ADDR_CTRL0);
        chk("ctrl0", rdVal, 32'h0000_0f9e);
        chk("testMode", {31'h0, testMode}, 32'h1);
        wr(ADDR_CTRL0, 32'h0000_0000);
        wr(ADDR_STATUS, 32'h0000_00ff);
        rd(ADDR_STATUS);
        chk("status", rdVal, 32'h0000_0000);
    endtask

    task automatic resetCmd();
        wr(ADDR_CTRL0, 32'h0000_0001);
        rd(ADDR_STATUS);
        chk("status", rdVal, 32'h0000_0020);
        chk("linIrq", {31'h0, linIrq}, 32'h0);
        rd(ADDR_STATUS);
        chk("status", rdVal, 32'h0000_0000);
    endtask

    // break then sync byte, checking the uart gate during the break
    task automatic frame(input logic [31:0] ctl, input logic [31:0] sel,
                         input logic [31:0] uartExp);
        wr(ADDR_CTRL0, ctl);
        wr(ADDR_EDGESEL, sel);
        // compare above the nine-bit low run a data byte can hold
        wr(ADDR_BRKCMP, 32'h0000_0064);
        wr(ADDR_SYNCCMP, 32'd3);
        fork
            begin
                lin_master_model_i.sendBreak(13);
                lin_master_model_i.sendByte(8'h55);
            end
            begin
                repeat (200) @(posedge clk);
                #1;
                chk("uartRxd", {31'h0, uartRxd}, uartExp);
                // gate is open after the stop edge, so data bit 7 shows low
                repeat (700) @(posedge clk);
                #1;
                chk("uartRxd", {31'h0, uartRxd}, 32'h0);
            end
        join
    endtask

    // start on falling edge 1, stop on falling edge 5: eight bits
    task automatic syncFalling();
        frame(32'h0000_011c, 32'h0000_0051, 32'h1);
        chk("linIrq", {31'h0, linIrq}, 32'h1);
        rd(ADDR_SYNCVAL);
        chkRange("syncTimer", rdVal, 32'd15, 32'd17);
        rd(ADDR_STATUS);
        chk("status", rdVal, 32'h0000_000f);
        chk("linIrq", {31'h0, linIrq}, 32'h0);
    endtask

    // stop on rising edge 4: seven bits
    task automatic syncRising();
        frame(32'h0000_0080, 32'h0000_0041, 32'h0);
        rd(ADDR_SYNCVAL);
        chkRange("syncTimer", rdVal, 32'd13, 32'd15);
        rd(ADDR_STATUS);
        chk("status", rdVal, 32'h0000_000f);
    endtask

    // line held low past 4096 break ticks with both irqs masked
    task automatic breakError();
        wr(ADDR_CTRL0, 32'h0000_0c00);
        lin_master_model_i.hold(1'b0, 17000);
        lin_master_model_i.hold(1'b1, 40);
        chk("linIrq", {31'h0, linIrq}, 32'h0);
        wr(ADDR_CTRL0, 32'h0000_0000);
        #1;
        chk("linIrq", {31'h0, linIrq}, 32'h1);
        rd(ADDR_STATUS);
        chk("status", rdVal, 32'h0000_0011);
        chk("linIrq", {31'h0, linIrq}, 32'h0);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        rst_n = 1'b0;
        regAddr = 32'h0;
        regWrData = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        n_errors = 0;
        tests_run = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        resetValues();
        ctrlAccess();
        resetCmd();
        syncFalling();
        syncRising();
        breakError();
        conclude();
    end

    // a hang counts as a mismatch
    initial
    begin
        repeat (60000) @(posedge clk);
        n_errors++;
        conclude();
    end
endmodule
`default_nettype wire
